// ===== src/sys_config_regs.vh
// Purpose: constants for the reset, clock and boot configuration block
// Assumes: 100 MHz system clock, word-aligned wishbone registers
// Notes: offsets are byte addresses
`ifndef SYS_CONFIG_REGS_VH
`define SYS_CONFIG_REGS_VH

`define CTRL_OFS        8'h00
`define STATUS_OFS      8'h04
`define CLKDIV_OFS      8'h08
`define WDOG_LOAD_OFS   8'h0c
`define WDOG_COUNT_OFS  8'h10

`define CTRL_FW_RST     0
`define CTRL_DOZE       1
`define CTRL_SLEEP_EXT  2
`define CTRL_WDOG_EN    3
`define CTRL_KICK       4

`define CLKDIV_RESET    16'h0000
`define WDOG_LOAD_RESET 32'h000f_ffff

`define POR_TIME_US     4000
`define CLK_MHZ         100
`define REF_MHZ         44
`define SLOW_MHZ        1
`define SLEEP_KHZ       32
`define BUS_MIN_KHZ     32
`define BUS_MAX_MHZ     66

`define BOOT_SERIAL     2'b00
`define BOOT_FLASH      2'b01
`define BOOT_SDIO       2'b10
`define BOOT_RSVD       2'b11

`endif

// ===== src/reset_clock_boot_config.v
// Purpose: reset combining, power-on stretch, clock select and boot decode
// Assumes: all inputs synchronous to clk_sys_i
// Notes: wishbone classic slave, ack one cycle after request
//
// Function
// - reset the device from the pin, watchdog, firmware, host serial port or sdio.
// - hold power-on reset 4 ms past a stable core supply and drive it on the por pin.
// - decode the two boot-select pins into serial, flash, sdio or reserved boot.
// - serial boot loads firmware over the host serial port using the 44 MHz clock.
// - flash boot fetches firmware through the master/slave serial port.
// - sdio boot loads firmware from the host like serial boot but over sdio.
// - software sets the core and bus clock between 32 kHz and 66 MHz; here the divided tick reaches at most 44 MHz.
// - doze mode runs on the sleep clock from the 1 MHz or the external 32 kHz source.
// - every internal clock comes from the 44 MHz, 1 MHz and 32 kHz inputs.
// - the watchdog fires when its down-counter reaches zero before reload; here it fires on the 1 MHz tick that finds it at 1.
//
// Implementation choices: the address map and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
`include "sys_config_regs.vh"

module reset_clock_boot_config #(
	parameter POR_CYCLES = (`POR_TIME_US * `CLK_MHZ),
	parameter DIV_W      = 16
) (
	// clock and reset
	input  wire              clk_sys_i,
	input  wire              rst_n_i,
	// supply and reset pins
	input  wire              supply_ok_i,
	input  wire              ext_rst_n_i,
	output reg               por_n_o,
	input  wire              host_serial_rst_i,
	input  wire              sdio_rst_i,
	output reg               core_rst_n_o,
	// boot select pins
	input  wire              boot_select_lo_i,
	input  wire              boot_select_hi_i,
	output reg  [1:0]        boot_mode_o,
	output reg               boot_from_host_serial_o,
	output reg               boot_from_flash_o,
	output reg               boot_from_sdio_o,
	// clock sources
	input  wire              ref_clk_en_i,
	input  wire              slow_clk_en_i,
	input  wire              sleep_clk_en_i,
	output reg               core_clk_en_o,
	output reg               sleep_src_ext_o,
	// wishbone
	input  wire              wb_cyc_i,
	input  wire              wb_stb_i,
	input  wire              wb_we_i,
	input  wire [7:0]        wb_adr_i,
	input  wire [3:0]        wb_sel_i,
	input  wire [31:0]       wb_dat_i,
	output reg  [31:0]       wb_dat_o,
	output reg               wb_ack_o
);

	reg  [1:0]        rst_sync_reg;
	wire              rst_n;
	reg  [31:0]       por_cnt_reg;
	reg  [4:0]        ctrl_reg;
	reg  [DIV_W-1:0]  div_reg;
	reg  [DIV_W-1:0]  div_cnt_reg;
	reg  [31:0]       wd_load_reg;
	reg  [31:0]       wd_cnt_reg;
	reg               wd_fire_reg;
	reg               fw_rst_reg;
	reg  [1:0]        src_reg;
	reg               any_rst_reg;
	reg               boot_seen_reg;
	wire              req;
	wire              clk_tick;
	wire              doze;

	assign rst_n = rst_sync_reg[1];
	assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign doze  = ctrl_reg[`CTRL_DOZE];

	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i)
			rst_sync_reg <= 2'b00;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end

	// power-on reset stretch
	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			por_cnt_reg <= 32'h0000_0000;
			por_n_o     <= 1'b0;
		end else if (!supply_ok_i) begin
			por_cnt_reg <= 32'h0000_0000;
			por_n_o     <= 1'b0;
		end else if (por_cnt_reg < POR_CYCLES - 1) begin
			por_cnt_reg <= por_cnt_reg + 32'h0000_0001;
		end else begin
			por_n_o     <= 1'b1;
		end
	end

	// reset combine and synchronous release
	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			any_rst_reg  <= 1'b1;
			core_rst_n_o <= 1'b0;
		end else begin
			any_rst_reg  <= ~ext_rst_n_i | wd_fire_reg | fw_rst_reg
				| host_serial_rst_i | sdio_rst_i | ~por_n_o;
			core_rst_n_o <= ~any_rst_reg;
		end
	end

	// boot mode capture after reset release
	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			boot_seen_reg           <= 1'b0;
			boot_mode_o             <= `BOOT_SERIAL;
			boot_from_host_serial_o <= 1'b0;
			boot_from_flash_o       <= 1'b0;
			boot_from_sdio_o        <= 1'b0;
		end else if (!core_rst_n_o) begin
			boot_seen_reg <= 1'b0;
		end else if (!boot_seen_reg) begin
			boot_seen_reg           <= 1'b1;
			boot_mode_o             <= {boot_select_hi_i, boot_select_lo_i};
			boot_from_host_serial_o <= ({boot_select_hi_i, boot_select_lo_i}
				== `BOOT_SERIAL);
			boot_from_flash_o       <= ({boot_select_hi_i, boot_select_lo_i}
				== `BOOT_FLASH);
			boot_from_sdio_o        <= ({boot_select_hi_i, boot_select_lo_i}
				== `BOOT_SDIO);
		end
	end

	// clock source and divider
	always @(*) begin
		if (doze)
			src_reg = ctrl_reg[`CTRL_SLEEP_EXT] ? 2'b10 : 2'b01;
		else
			src_reg = 2'b00;
	end
	assign clk_tick = (src_reg == 2'b10) ? sleep_clk_en_i :
		(src_reg == 2'b01) ? slow_clk_en_i :
		ref_clk_en_i;

	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt_reg     <= {DIV_W{1'b0}};
			core_clk_en_o   <= 1'b0;
			sleep_src_ext_o <= 1'b0;
		end else begin
			sleep_src_ext_o <= ctrl_reg[`CTRL_SLEEP_EXT];
			core_clk_en_o   <= 1'b0;
			if (clk_tick) begin
				if (div_cnt_reg >= div_reg || boot_from_host_serial_o) begin
					div_cnt_reg   <= {DIV_W{1'b0}};
					core_clk_en_o <= 1'b1;
				end else begin
					div_cnt_reg <= div_cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};
				end
			end
		end
	end

	// watchdog down-counter on the 1 MHz tick
	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			wd_cnt_reg  <= `WDOG_LOAD_RESET;
			wd_fire_reg <= 1'b0;
		end else if (!core_rst_n_o) begin
			wd_cnt_reg  <= wd_load_reg;
			wd_fire_reg <= 1'b0;
		end else if (req && wb_we_i && wb_adr_i == `CTRL_OFS && wb_sel_i[0]
			&& wb_dat_i[`CTRL_KICK]) begin
			wd_cnt_reg <= wd_load_reg;
		end else if (ctrl_reg[`CTRL_WDOG_EN] && slow_clk_en_i) begin
			if (wd_cnt_reg == 32'h0000_0001 || wd_cnt_reg == 32'h0000_0000)
				wd_fire_reg <= 1'b1;
			else
				wd_cnt_reg <= wd_cnt_reg - 32'h0000_0001;
		end
	end

	// wishbone registers
	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o    <= 1'b0;
			wb_dat_o    <= 32'h0000_0000;
			ctrl_reg    <= 5'h00;
			fw_rst_reg  <= 1'b0;
			div_reg     <= `CLKDIV_RESET;
			wd_load_reg <= `WDOG_LOAD_RESET;
		end else begin
			wb_ack_o   <= req;
			fw_rst_reg <= 1'b0;
			if (!core_rst_n_o)
				ctrl_reg <= 5'h00;
			if (req && wb_we_i) begin
				if (wb_adr_i == `CTRL_OFS) begin
					if (wb_sel_i[0]) begin
						ctrl_reg   <= {1'b0, wb_dat_i[3:0]};
						fw_rst_reg <= wb_dat_i[`CTRL_FW_RST];
					end
				end else if (wb_adr_i == `CLKDIV_OFS) begin
					if (wb_sel_i[0])
						div_reg[7:0] <= wb_dat_i[7:0];
					if (wb_sel_i[1])
						div_reg[DIV_W-1:8] <= wb_dat_i[DIV_W-1:8];
				end else if (wb_adr_i == `WDOG_LOAD_OFS) begin
					if (wb_sel_i[0])
						wd_load_reg[7:0] <= wb_dat_i[7:0];
					if (wb_sel_i[1])
						wd_load_reg[15:8] <= wb_dat_i[15:8];
					if (wb_sel_i[2])
						wd_load_reg[23:16] <= wb_dat_i[23:16];
					if (wb_sel_i[3])
						wd_load_reg[31:24] <= wb_dat_i[31:24];
				end
			end
			if (req && !wb_we_i) begin
				if (wb_adr_i == `CTRL_OFS)
					wb_dat_o <= {27'h0, 1'b0, ctrl_reg[3:0]};
				else if (wb_adr_i == `STATUS_OFS)
					wb_dat_o <= {24'h0, boot_from_sdio_o, boot_from_flash_o,
						boot_from_host_serial_o, sleep_src_ext_o, doze,
						boot_mode_o, por_n_o};
				else if (wb_adr_i == `CLKDIV_OFS)
					wb_dat_o <= {{(32-DIV_W){1'b0}}, div_reg};
				else if (wb_adr_i == `WDOG_LOAD_OFS)
					wb_dat_o <= wd_load_reg;
				else if (wb_adr_i == `WDOG_COUNT_OFS)
					wb_dat_o <= wd_cnt_reg;
				else
					wb_dat_o <= 32'h0000_0000;
			end
		end
	end

endmodule
`default_nettype wire

// ===== verification/reset_clock_boot_config_chk.sv
// Purpose: port checks for the reset and boot block
// Assumes: one clock domain, registered outputs
// Notes: bind follows the module
`timescale 1ns/10ps
`default_nettype none
module reset_clock_boot_config_chk #(parameter POR_CYCLES = 400000) (
	// watched ports
	input wire logic       clk_sys_i,
	input wire logic       rst_n_i,
	input wire logic       supply_ok_i,
	input wire logic       host_serial_rst_i,
	input wire logic       sdio_rst_i,
	input wire logic       por_n_o,
	input wire logic       core_rst_n_o,
	input wire logic [1:0] boot_mode_o,
	input wire logic       boot_from_host_serial_o,
	input wire logic       boot_from_flash_o,
	input wire logic       boot_from_sdio_o,
	input wire logic       ref_clk_en_i,
	input wire logic       slow_clk_en_i,
	input wire logic       sleep_clk_en_i,
	input wire logic       core_clk_en_o,
	input wire logic       wb_cyc_i,
	input wire logic       wb_ack_o
);
	logic [31:0] up_reg;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
		if (!rst_n_i) up_reg <= 32'h0;
		else up_reg <= supply_ok_i ? up_reg + 32'h1 : 32'h0;
	por_stretch_a: assert property ($rose(por_n_o) |-> up_reg >= POR_CYCLES
		&& up_reg <= POR_CYCLES + 2) else $error("por release time wrong");
	host_reset_a: assert property (host_serial_rst_i |-> ##2 !core_rst_n_o)
		else $error("host reset ignored");
	sdio_reset_a: assert property (sdio_rst_i |-> ##2 !core_rst_n_o)
		else $error("sdio reset ignored");
	release_sync_a: assert property ($rose(core_rst_n_o) |-> $past(por_n_o, 2)
		&& !$past(host_serial_rst_i, 2) && !$past(sdio_rst_i, 2)) else $error("early release");
	boot_decode_a: assert property (core_rst_n_o [*4] |->
		boot_from_host_serial_o == (boot_mode_o == 2'h0) && boot_from_flash_o ==
		(boot_mode_o == 2'h1) && boot_from_sdio_o == (boot_mode_o == 2'h2)) else $error("decode");
	clk_source_a: assert property (core_clk_en_o |-> $past(ref_clk_en_i)
		|| $past(slow_clk_en_i) || $past(sleep_clk_en_i)) else $error("clock without tick");
	ack_answer_a: assert property (wb_cyc_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	cover property ($rose(por_n_o));
	cover property ($rose(core_rst_n_o) && boot_mode_o == 2'h2);
	cover property (core_clk_en_o && boot_from_flash_o);
endmodule
bind reset_clock_boot_config reset_clock_boot_config_chk #(.POR_CYCLES(POR_CYCLES)) chk_inst (
	.clk_sys_i, .rst_n_i, .supply_ok_i, .host_serial_rst_i, .sdio_rst_i, .por_n_o,
	.core_rst_n_o, .boot_mode_o, .boot_from_host_serial_o, .boot_from_flash_o,
	.boot_from_sdio_o, .ref_clk_en_i, .slow_clk_en_i, .sleep_clk_en_i, .core_clk_en_o,
	.wb_cyc_i, .wb_ack_o);
`default_nettype wire

// ===== verification/boot_host_model.sv
// Purpose: host side: boot pins, reset requests, clock ticks
// Assumes: 100 MHz system clock
// Notes: clocks are one-cycle enables
`timescale 1ns/10ps
`default_nettype none
module boot_host_model (
	// from bench
	input  wire logic       clk_i,
	input  wire logic [1:0] mode_i,
	input  wire logic       host_req_i,
	input  wire logic       sdio_req_i,
	// to the block
	output var logic [1:0]  pins_o = 2'h0,
	output var logic        host_rst_o = 1'b0,
	output var logic        sdio_rst_o = 1'b0,
	output var logic        ref_o = 1'b0,
	output var logic        slow_o = 1'b0,
	output var logic        sleep_o = 1'b0
);
	logic [6:0] acc = 7'h0;
	logic [6:0] cnt = 7'h0;
	logic [4:0] slp = 5'h0;
	always_ff @(posedge clk_i) begin
		pins_o <= mode_i;
		host_rst_o <= host_req_i;
		sdio_rst_o <= sdio_req_i;
		acc <= (acc >= 7'h38) ? acc - 7'h38 : acc + 7'h2c;
		ref_o <= acc >= 7'h38;
		cnt <= (cnt == 7'h63) ? 7'h0 : cnt + 7'h1;
		slow_o <= cnt == 7'h63;
		slp <= slp + {4'h0, cnt == 7'h63};
		sleep_o <= cnt == 7'h63 && slp == 5'h1f;
	end
endmodule
`default_nettype wire

// ===== verification/reset_clock_boot_config_tb_top.sv
// Purpose: bench for reset_clock_boot_config
// Assumes: power-on stretch shortened to 20 cycles
// Notes: wishbone master task, host model on the pins
`timescale 1ns/10ps
`default_nettype none
`include "sys_config_regs.vh"
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin fail_count++; \
	$display("Error %s expected %h seen %h", nm, e, s); end end
module reset_clock_boot_config_tb_top;
	logic clk_sys_i = 1'b0, rst_n_i = 1'b0, sup = 1'b0, cyc = 1'b0, we = 1'b0;
	logic hreq = 1'b0, sreq = 1'b0;
	logic [1:0] mode = 2'h0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0, rd;
	wire por_n, core_n, h_rst, s_rst, t_ref, t_slow, t_slp, core_en, sl_ext, ack;
	wire [1:0] pins, bmode;
	wire b_ser, b_fl, b_sd;
	wire [31:0] dat_o;
	int fail_count = 0, checks_done = 0, n, k;
	always #5 clk_sys_i = ~clk_sys_i;
	boot_host_model boot_host_model_inst (.clk_i(clk_sys_i), .mode_i(mode), .host_req_i(hreq),
		.sdio_req_i(sreq), .pins_o(pins), .host_rst_o(h_rst), .sdio_rst_o(s_rst),
		.ref_o(t_ref), .slow_o(t_slow), .sleep_o(t_slp));
	reset_clock_boot_config #(.POR_CYCLES(20)) reset_clock_boot_config_inst (
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .supply_ok_i(sup), .por_n_o(por_n),
		.ext_rst_n_i(por_n),
		.host_serial_rst_i(h_rst), .sdio_rst_i(s_rst), .core_rst_n_o(core_n),
		.boot_select_lo_i(pins[0]), .boot_select_hi_i(pins[1]), .boot_mode_o(bmode),
		.boot_from_host_serial_o(b_ser), .boot_from_flash_o(b_fl), .boot_from_sdio_o(b_sd),
		.ref_clk_en_i(t_ref), .slow_clk_en_i(t_slow), .sleep_clk_en_i(t_slp),
		.core_clk_en_o(core_en), .sleep_src_ext_o(sl_ext), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o),
		.wb_ack_o(ack));
	task wrap_up;
		$display("fail_count %0d checks_done %0d", fail_count, checks_done);
		if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		n = 0;
		do @(posedge clk_sys_i); while (ack !== 1'b1 && ++n < 99);
		rd = dat_o;
		cyc <= 1'b0;
		if (n >= 99) begin fail_count++; wrap_up; end
	endtask
	task wait_rst(input logic v);
		n = 0;
		do @(posedge clk_sys_i); while (core_n !== v && ++n < 3000);
		if (n >= 3000) begin fail_count++; wrap_up; end
	endtask
	task div_chk(input int lo, input int hi);
		int r, c, t;
		bus(1'b1, `CLKDIV_OFS, 32'h3);
		r = 0;
		c = 0;
		t = 0;
		do begin @(posedge clk_sys_i); r += t_ref; c += core_en; t++; end
			while (r < 40 && t < 999);
		if (t >= 999) begin fail_count++; wrap_up; end
		`CHK("core ticks", 1'b1, c >= lo && c <= hi)
	endtask
	initial begin
		repeat (16) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		`CHK("por held", 1'b0, por_n)
		sup <= 1'b1;
		do @(posedge clk_sys_i); while (por_n !== 1'b1 && ++n < 99);
		`CHK("por stretch", 1'b1, n >= 18 && n <= 23)
		wait_rst(1'b1);
		bus(1'b0, `CLKDIV_OFS, 32'h0);
		`CHK("clkdiv reset", {16'h0, `CLKDIV_RESET}, rd)
		bus(1'b0, `WDOG_LOAD_OFS, 32'h0);
		`CHK("load reset", `WDOG_LOAD_RESET, rd)
		bus(1'b1, 8'h3c, 32'hffff_ffff);
		bus(1'b0, 8'h3c, 32'h0);
		`CHK("unmapped", 32'h0, rd)
		for (k = 0; k < 4; k++) begin
			mode <= k[1:0];
			hreq <= k == 0;
			sreq <= k == 1;
			if (k == 2) bus(1'b1, `CTRL_OFS, 32'h1);
			if (k == 3) bus(1'b1, `WDOG_LOAD_OFS, 32'h3);
			if (k == 3) bus(1'b1, `CTRL_OFS, 32'h18);
			@(posedge clk_sys_i);
			hreq <= 1'b0;
			sreq <= 1'b0;
			wait_rst(1'b0);
			wait_rst(1'b1);
			bus(1'b0, `STATUS_OFS, 32'h0);
			`CHK("status", {k == 2, k == 1, k == 0, 2'h0, k[1:0], 1'b1}, rd[7:0])
			`CHK("boot pins", {k == 2, k == 1, k == 0, k[1:0]}, {b_sd, b_fl, b_ser, bmode})
			if (k < 2) div_chk(k ? 9 : 38, k ? 11 : 41);
		end
		bus(1'b1, `CTRL_OFS, 32'h6);
		repeat (2) @(posedge clk_sys_i);
		`CHK("ext sleep", 1'b1, sl_ext)
		bus(1'b0, `STATUS_OFS, 32'h0);
		`CHK("doze status", 8'h1f, rd[7:0])
		bus(1'b1, `CTRL_OFS, 32'h2);
		repeat (2) @(posedge clk_sys_i);
		`CHK("int sleep", 1'b0, sl_ext)
		bus(1'b1, `CLKDIV_OFS, 32'h0);
		k = 0;
		repeat (1000) begin @(posedge clk_sys_i); k += core_en; end
		`CHK("doze ticks", 1'b1, k >= 9 && k <= 11)
		wrap_up;
	end
endmodule
`default_nettype wire
